//--- design/pgen_timing_pkg.sv
/*
 * Constants, field layouts and the carrier type for the test-pattern
 * timing block. Assumes a byte-wide register port in the main map.
 */
package pgen_timing_pkg;

	// ---------------------------------------------------------------
	// Main-map offsets
	// ---------------------------------------------------------------
	localparam logic [7:0] MAIN_INDIRECT_INDEX = 8'h66;
	localparam logic [7:0] MAIN_INDIRECT_DATA = 8'h67;

	// ---------------------------------------------------------------
	// Indirect offsets
	// ---------------------------------------------------------------
	localparam logic [7:0] OFS_TOTAL_HORIZ_LOWER = 8'h04;
	localparam logic [7:0] OFS_TOTAL_SIZE_NIBBLES = 8'h05;
	localparam logic [7:0] OFS_TOTAL_VERTICAL_UPPER = 8'h06;
	localparam logic [7:0] OFS_ACTIVE_HORIZONTAL_LOWER = 8'h07;
	localparam logic [7:0] OFS_ACTIVE_SIZE_NIBBLES = 8'h08;
	localparam logic [7:0] OFS_ACTIVE_VERTICAL_UPPER = 8'h09;
	localparam logic [7:0] OFS_HSYNC_PULSE_WIDTH = 8'h0A;
	localparam logic [7:0] OFS_VSYNC_PULSE_WIDTH = 8'h0B;
	localparam logic [7:0] OFS_HORIZ_BACK_PORCH = 8'h0C;
	localparam logic [7:0] OFS_VERT_BACK_PORCH = 8'h0D;
	localparam logic [7:0] OFS_SYNC_CONTROL = 8'h0E;
	localparam int NUM_CFG = 11;

	// ---------------------------------------------------------------
	// Reset values
	// ---------------------------------------------------------------
	localparam logic [7:0] RST_TOTAL_HORIZ_LOWER = 8'h48;
	localparam logic [7:0] RST_TOTAL_SIZE_NIBBLES = 8'h53;
	localparam logic [7:0] RST_TOTAL_VERTICAL_UPPER = 8'h1E;
	localparam logic [7:0] RST_ACTIVE_HORIZONTAL_LOWER = 8'h20;
	localparam logic [7:0] RST_ACTIVE_SIZE_NIBBLES = 8'h03;
	localparam logic [7:0] RST_ACTIVE_VERTICAL_UPPER = 8'h1E;
	localparam logic [7:0] RST_HSYNC_PULSE_WIDTH = 8'h0A;
	localparam logic [7:0] RST_VSYNC_PULSE_WIDTH = 8'h02;
	localparam logic [7:0] RST_HORIZ_BACK_PORCH = 8'h0A;
	localparam logic [7:0] RST_VERT_BACK_PORCH = 8'h02;
	localparam logic [7:0] RST_SYNC_CONTROL = 8'h03;
	localparam logic [7:0] RST_INDIRECT_INDEX = 8'h00;

	// ---------------------------------------------------------------
	// Field positions
	// ---------------------------------------------------------------
	localparam int NIB_LO_LSB = 0;
	localparam int NIB_HI_LSB = 4;
	localparam int SC_HS_POL_BIT = 0;
	localparam int SC_VS_POL_BIT = 1;
	localparam int SC_HS_DIS_BIT = 2;
	localparam logic [7:0] SC_WRITABLE_MASK = 8'h07;

	typedef struct packed {
		logic [11:0] total_horiz_pixels;
		logic [11:0] total_vert_lines;
		logic [11:0] active_horiz_pixels;
		logic [11:0] active_vert_lines;
		logic [7:0] hsync_pixels;
		logic [7:0] vsync_lines;
		logic [7:0] horiz_porch_pixels;
		logic [7:0] vert_porch_lines;
		logic hs_pol;
		logic vs_pol;
		logic hs_dis;
	} timing_cfg_t;

endpackage : pgen_timing_pkg

//--- design/pattern_gen_video_timing.sv
/*
 * Indirect timing register set and raster timing counters of the
 * test-pattern generator.
 * Assumes a synchronous byte-wide main-map register port, a pixel
 * rate given by clk_en, and an enable input from the control map.
 */
//
// Contract
// - Total horizontal pixels: 12 bits, upper nibble in bits 3-0 of nibble byte.
// - Total vertical lines: 12 bits, low nibble bits 7-4, upper byte separate.
// - Active horizontal pixels: 12 bits, low byte then bits 3-0 next byte.
// - Active vertical lines: 12 bits, low nibble bits 7-4 shared, upper byte next.
// - Hsync pulse lasts programmed pixels, legal 1 to 255.
// - Vsync pulse lasts programmed lines, legal 1 to 255.
// - Horizontal back porch lasts programmed pixels, legal 1 to 255.
// - Vertical back porch lasts programmed lines, legal 1 to 255.
// - Reset: hsync and horizontal porch ten pixels, vertical ones two lines.
// - Reset: active bytes hold 20h, 03h and 1Eh.
`timescale 1ns/1ps

module pattern_gen_video_timing #(
	parameter int CNT_W = 12
) (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic clk_en,
	input wire logic pattern_enable,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	output logic hsync,
	output logic vsync,
	output logic data_enable
);

	// ---------------------------------------------------------------
	// Indirect register file
	// ---------------------------------------------------------------
	logic [7:0] indirect_index_q;
	logic [7:0] cfg_q [pgen_timing_pkg::NUM_CFG];
	logic [7:0] rdata_q;
	logic [7:0] idx_off;
	logic idx_hit;
	logic [7:0] indirect_data;
	pgen_timing_pkg::timing_cfg_t cfg;

	assign idx_off = indirect_index_q - pgen_timing_pkg::OFS_TOTAL_HORIZ_LOWER;
	assign idx_hit = (indirect_index_q >= pgen_timing_pkg::OFS_TOTAL_HORIZ_LOWER) &&
		(indirect_index_q <= pgen_timing_pkg::OFS_SYNC_CONTROL);
	assign indirect_data = idx_hit ? cfg_q[idx_off[3:0]] : 8'h00;

	// Index register in the main map
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			indirect_index_q <= pgen_timing_pkg::RST_INDIRECT_INDEX;
		end else if (clk_en && reg_wr && reg_addr == pgen_timing_pkg::MAIN_INDIRECT_INDEX) begin
			indirect_index_q <= reg_wdata;
		end
	end

	// Data register writes land at the indexed setting
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			cfg_q[0] <= pgen_timing_pkg::RST_TOTAL_HORIZ_LOWER;
			cfg_q[1] <= pgen_timing_pkg::RST_TOTAL_SIZE_NIBBLES;
			cfg_q[2] <= pgen_timing_pkg::RST_TOTAL_VERTICAL_UPPER;
			cfg_q[3] <= pgen_timing_pkg::RST_ACTIVE_HORIZONTAL_LOWER;
			cfg_q[4] <= pgen_timing_pkg::RST_ACTIVE_SIZE_NIBBLES;
			cfg_q[5] <= pgen_timing_pkg::RST_ACTIVE_VERTICAL_UPPER;
			cfg_q[6] <= pgen_timing_pkg::RST_HSYNC_PULSE_WIDTH;
			cfg_q[7] <= pgen_timing_pkg::RST_VSYNC_PULSE_WIDTH;
			cfg_q[8] <= pgen_timing_pkg::RST_HORIZ_BACK_PORCH;
			cfg_q[9] <= pgen_timing_pkg::RST_VERT_BACK_PORCH;
			cfg_q[10] <= pgen_timing_pkg::RST_SYNC_CONTROL;
		end else if (clk_en && reg_wr && reg_addr == pgen_timing_pkg::MAIN_INDIRECT_DATA &&
			idx_hit) begin
			if (indirect_index_q == pgen_timing_pkg::OFS_SYNC_CONTROL) begin
				cfg_q[idx_off[3:0]] <= reg_wdata & pgen_timing_pkg::SC_WRITABLE_MASK;
			end else begin
				cfg_q[idx_off[3:0]] <= reg_wdata;
			end
		end
	end

	// Read answer, registered
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			rdata_q <= 8'h00;
		end else if (clk_en && reg_rd) begin
			unique case (reg_addr)
				pgen_timing_pkg::MAIN_INDIRECT_INDEX: rdata_q <= indirect_index_q;
				pgen_timing_pkg::MAIN_INDIRECT_DATA: rdata_q <= indirect_data;
				default: rdata_q <= 8'h00;
			endcase
		end
	end
	assign reg_rdata = rdata_q;

	// ---------------------------------------------------------------
	// Field assembly
	// ---------------------------------------------------------------
	localparam int NH = pgen_timing_pkg::NIB_HI_LSB;
	localparam int NL = pgen_timing_pkg::NIB_LO_LSB;

	always_comb begin
		cfg.total_horiz_pixels = {cfg_q[1][NL +: 4], cfg_q[0]};
		cfg.total_vert_lines = {cfg_q[2], cfg_q[1][NH +: 4]};
		cfg.active_horiz_pixels = {cfg_q[4][NL +: 4], cfg_q[3]};
		cfg.active_vert_lines = {cfg_q[5], cfg_q[4][NH +: 4]};
		cfg.hsync_pixels = cfg_q[6];
		cfg.vsync_lines = cfg_q[7];
		cfg.horiz_porch_pixels = cfg_q[8];
		cfg.vert_porch_lines = cfg_q[9];
		cfg.hs_pol = cfg_q[10][pgen_timing_pkg::SC_HS_POL_BIT];
		cfg.vs_pol = cfg_q[10][pgen_timing_pkg::SC_VS_POL_BIT];
		cfg.hs_dis = cfg_q[10][pgen_timing_pkg::SC_HS_DIS_BIT];
	end

	// ---------------------------------------------------------------
	// Raster counters
	// ---------------------------------------------------------------
	logic [CNT_W-1:0] hcnt_q;
	logic [CNT_W-1:0] vcnt_q;
	logic h_last;
	logic v_last;
	logic [CNT_W:0] h_bp_end;
	logic [CNT_W:0] h_act_end;
	logic [CNT_W:0] v_bp_end;
	logic [CNT_W:0] v_act_end;
	logic h_sync_on;
	logic v_sync_on;
	logic h_act_on;
	logic v_act_on;

	// Settings are assumed static while enabled
	assign h_last = ({1'b0, hcnt_q} + (CNT_W+1)'(1)) >= {1'b0, cfg.total_horiz_pixels};
	assign v_last = ({1'b0, vcnt_q} + (CNT_W+1)'(1)) >= {1'b0, cfg.total_vert_lines};

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			hcnt_q <= '0;
		end else if (clk_en) begin
			if (!pattern_enable || h_last) begin
				hcnt_q <= '0;
			end else begin
				hcnt_q <= hcnt_q + CNT_W'(1);
			end
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			vcnt_q <= '0;
		end else if (clk_en) begin
			if (!pattern_enable) begin
				vcnt_q <= '0;
			end else if (h_last) begin
				vcnt_q <= v_last ? '0 : vcnt_q + CNT_W'(1);
			end
		end
	end

	// Sync, then back porch, then active, then front porch
	always_comb begin
		h_bp_end = (CNT_W+1)'(cfg.hsync_pixels) + (CNT_W+1)'(cfg.horiz_porch_pixels);
		h_act_end = h_bp_end + (CNT_W+1)'(cfg.active_horiz_pixels);
		v_bp_end = (CNT_W+1)'(cfg.vsync_lines) + (CNT_W+1)'(cfg.vert_porch_lines);
		v_act_end = v_bp_end + (CNT_W+1)'(cfg.active_vert_lines);
		h_sync_on = {1'b0, hcnt_q} < (CNT_W+1)'(cfg.hsync_pixels);
		v_sync_on = {1'b0, vcnt_q} < (CNT_W+1)'(cfg.vsync_lines);
		h_act_on = ({1'b0, hcnt_q} >= h_bp_end) && ({1'b0, hcnt_q} < h_act_end);
		v_act_on = ({1'b0, vcnt_q} >= v_bp_end) && ({1'b0, vcnt_q} < v_act_end);
	end

	// ---------------------------------------------------------------
	// Registered video outputs
	// ---------------------------------------------------------------
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			hsync <= 1'b0;
			vsync <= 1'b0;
			data_enable <= 1'b0;
		end else if (clk_en) begin
			hsync <= (pattern_enable && h_sync_on && !cfg.hs_dis) ^ cfg.hs_pol;
			vsync <= (pattern_enable && v_sync_on) ^ cfg.vs_pol;
			data_enable <= pattern_enable && h_act_on && v_act_on;
		end
	end

endmodule : pattern_gen_video_timing

//--- verification/pgen_timing_properties.sv
/* Port checker for the pattern timing block.
   Assumes sync polarity and disable stay at reset while running; settings legal. */
`timescale 1ns/1ps
module pgen_timing_properties (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic clk_en,
	input wire logic pattern_enable,
	input wire logic [7:0] reg_addr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic hsync,
	input wire logic vsync,
	input wire logic data_enable
);
	// ------
	// Properties
	// ------
	default clocking @(posedge mclk); endclocking
	default disable iff (!nrst);
	property p_rd_hold; clk_en && !reg_rd |=> $stable(reg_rdata); endproperty
	a_rd_hold: assert property (p_rd_hold) else $error("rdata moved");
	property p_unmapped;
		clk_en && reg_rd && reg_addr != 8'h66 && reg_addr != 8'h67 |=> reg_rdata == 8'h00;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read");
	property p_off_dark; !pattern_enable [*2] |-> !data_enable; endproperty
	a_off_dark: assert property (p_off_dark) else $error("video while off");
	property p_off_still;
		!pattern_enable [*3] |-> $stable(hsync) && $stable(vsync);
	endproperty
	a_off_still: assert property (p_off_still) else $error("sync moves off");
	property p_video_quiet; data_enable && $past(data_enable) |-> $stable(hsync); endproperty
	a_video_quiet: assert property (p_video_quiet) else $error("sync in video");
	property p_blank_gap; $fell(data_enable) |-> !data_enable [*2]; endproperty
	a_blank_gap: assert property (p_blank_gap) else $error("short blank");
	property p_v_with_h;
		pattern_enable && $past(pattern_enable) && $changed(vsync) |-> $changed(hsync);
	endproperty
	a_v_with_h: assert property (p_v_with_h) else $error("vsync off line");
	property p_de_rise; $rose(data_enable) |-> $stable(vsync); endproperty
	a_de_rise: assert property (p_de_rise) else $error("vsync at video");
	property p_freeze;
		!clk_en |=> $stable(hsync) && $stable(vsync) && $stable(data_enable) && $stable(reg_rdata);
	endproperty
	a_freeze: assert property (p_freeze) else $error("moved while frozen");
endmodule : pgen_timing_properties

//--- verification/tb.sv
/* Self-checking bench for the pattern timing block.
   Assumes the checker module is compiled first. */
`timescale 1ns/1ps
module tb;
	logic mclk = 1'b0, nrst = 1'b0, clk_en = 1'b1, pattern_enable = 1'b0;
	logic reg_wr = 1'b0, reg_rd = 1'b0, hsync, vsync, data_enable;
	logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, d;
	int bad_count = 0, tests_run = 0;
	pattern_gen_video_timing dut (.mclk(mclk), .nrst(nrst), .clk_en(clk_en),
		.pattern_enable(pattern_enable), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .hsync(hsync),
		.vsync(vsync), .data_enable(data_enable));
	initial begin
		forever #4 mclk = ~mclk;
	end
	// ------
	// Helpers
	// ------
	task automatic end_sim;
		$display("Checks %0d, mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : end_sim
	task automatic chk(input string n, input logic [11:0] e, input logic [11:0] g);
		tests_run++;
		if (g !== e) begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(negedge mclk);
		reg_wr = 1'b1;
		reg_addr = a;
		reg_wdata = v;
		@(negedge mclk);
		reg_wr = 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a);
		@(negedge mclk);
		reg_rd = 1'b1;
		reg_addr = a;
		@(negedge mclk);
		reg_rd = 1'b0;
		d = reg_rdata;
	endtask : rd
	task automatic ird(input logic [7:0] o);
		wr(8'h66, o);
		rd(8'h67);
	endtask : ird
	function automatic logic sig(input int s);
		return s == 0 ? hsync : s == 1 ? vsync : data_enable;
	endfunction : sig
	// ------
	// Scenarios
	// ------
	task automatic reset_values;
		logic [7:0] e[11] = '{8'h48, 8'h53, 8'h1E, 8'h20, 8'h03, 8'h1E, 8'h0A, 8'h02,
			8'h0A, 8'h02, 8'h03};
		rd(8'h66);
		chk("index reset", 12'h000, {4'h0, d});
		for (int i = 0; i < 11; i++) begin
			ird(8'h04 + 8'(i));
			chk("reset byte", {4'h0, e[i]}, {4'h0, d});
		end
	endtask : reset_values
	task automatic field_access;
		for (int i = 4; i < 14; i++) begin
			wr(8'h66, 8'(i));
			wr(8'h67, 8'(i * 17));
			ird(8'(i));
			chk("setting", {4'h0, 8'(i * 17)}, {4'h0, d});
		end
		wr(8'h66, 8'h0E);
		wr(8'h67, 8'hFF);
		ird(8'h0E);
		chk("sync control", 12'h007, {4'h0, d});
		wr(8'h67, 8'h03);
		ird(8'h20);
		chk("unused index", 12'h000, {4'h0, d});
		wr(8'h10, 8'hFF);
		rd(8'h10);
		chk("unmapped", 12'h000, {4'h0, d});
		rd(8'h66);
		chk("index", 12'h020, {4'h0, d});
	endtask : field_access
	task automatic raster;
		logic [7:0] c[10] = '{8'h18, 8'hC0, 8'h00, 8'h06, 8'h30, 8'h00, 8'h03, 8'h02,
			8'h02, 8'h01};
		int s[10] = '{1, 0, 0, 2, 2, 2, 2, 2, 2, 2};
		int e[10] = '{48, 3, 21, 5, 6, 18, 6, 18, 6, 234};
		int n;
		for (int i = 0; i < 10; i++) begin
			wr(8'h66, 8'h04 + 8'(i));
			wr(8'h67, c[i]);
		end
		@(negedge mclk);
		pattern_enable = 1'b1;
		for (int i = 0; i < 10; i++) begin
			for (int w = 0; sig(s[i]) !== (i > 1 && i % 2 == 0); w++) begin
				if (w > 400) begin
					bad_count++;
					end_sim();
				end
				@(negedge mclk);
			end
			n = 0;
			while (sig(s[i]) === (i > 1 && i % 2 == 0) && n < 1000) begin
				n++;
				@(negedge mclk);
			end
			chk("run length", 12'(e[i]), 12'(n));
		end
		pattern_enable = 1'b0;
	endtask : raster
	task automatic clk_hold;
		int n;
		@(negedge mclk);
		pattern_enable = 1'b1;
		@(negedge mclk);
		clk_en = 1'b0;
		reg_wr = 1'b1;
		reg_addr = 8'h66;
		reg_wdata = 8'h0B;
		repeat (4) @(negedge mclk);
		chk("frozen hsync", 12'h000, {11'h000, hsync});
		clk_en = 1'b1;
		reg_wr = 1'b0;
		n = 0;
		while (hsync === 1'b0 && n < 50) begin
			n++;
			@(negedge mclk);
		end
		chk("hsync after freeze", 12'h003, 12'(n));
		pattern_enable = 1'b0;
		rd(8'h66);
		chk("index held", 12'h00D, {4'h0, d});
	endtask : clk_hold
	task automatic mid_reset;
		@(negedge mclk);
		pattern_enable = 1'b1;
		repeat (30) @(negedge mclk);
		nrst = 1'b0;
		pattern_enable = 1'b0;
		repeat (2) @(negedge mclk);
		chk("outputs in reset", 12'h000, {9'h000, hsync, vsync, data_enable});
		chk("rdata in reset", 12'h000, {4'h0, reg_rdata});
		nrst = 1'b1;
		reset_values();
	endtask : mid_reset
	initial begin
		repeat (3) @(negedge mclk);
		nrst = 1'b1;
		reset_values();
		field_access();
		raster();
		clk_hold();
		mid_reset();
		end_sim();
	end
endmodule : tb
bind pattern_gen_video_timing pgen_timing_properties chk_i (.mclk(mclk), .nrst(nrst),
	.clk_en(clk_en), .pattern_enable(pattern_enable), .reg_addr(reg_addr),
	.reg_rd(reg_rd), .reg_rdata(reg_rdata), .hsync(hsync), .vsync(vsync),
	.data_enable(data_enable));
